/* File: design/ioare_pkg.sv */
// Constants for the interrupt routing table block.
// Assumes a 32-bit register port at the offsets named below.
package ioare_pkg;

  // ----------------------------------------
  // Register offsets and index map
  // ----------------------------------------
  localparam logic [7:0] OFS_INDEX = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_PIN = 8'h20;
  localparam logic [7:0] OFS_EOI = 8'h40;
  localparam logic [7:0] IDX_ENTRY_BASE = 8'h10;
  localparam int NUM_INPUTS = 24;

  // ----------------------------------------
  // Low-word field positions of an entry
  // ----------------------------------------
  localparam int VEC_LSB = 0;
  localparam int DELIV_LSB = 8;
  localparam int B_LOGICAL = 11;
  localparam int B_PENDING = 12;
  localparam int B_POLARITY = 13;
  localparam int B_REMOTE = 14;
  localparam int B_LEVEL = 15;
  localparam int B_MASK = 16;
  // High word: destination in bits 31:24 (entry bits 63:56)
  localparam int DEST_LSB = 24;

  // ----------------------------------------
  // Delivery modes and reset values
  // ----------------------------------------
  localparam logic [2:0] DELIV_RSVD_A = 3'h3;
  localparam logic [2:0] DELIV_RSVD_B = 3'h6;
  localparam logic [7:0] VEC_RST = 8'h00;
  localparam logic [7:0] DEST_RST = 8'h00;
  localparam logic [2:0] DELIV_RST = 3'h0;
  localparam logic [3:0] PHYS_PAD = 4'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Message sender states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } ioare_state_e;

endpackage

/* File: design/ioare_top.sv */
// Routing table of an interrupt controller: 24 entries, index/data access,
// pin assertion and end-of-interrupt registers, one message sender.
// Assumes inputs synchronous to ref_clk and a message bus that accepts
// an offered message by pulsing msg_accept while msg_valid is high.
`timescale 1ns/1ps
`default_nettype none

module ioare_top #(
  parameter int N = ioare_pkg::NUM_INPUTS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Interrupt inputs
  input wire logic [N-1:0] irq_in,
  // Interrupt message bus
  output logic msg_valid,
  output logic [7:0] msg_vector,
  output logic [7:0] msg_dest,
  output logic msg_logical,
  output logic [2:0] msg_delivery,
  output logic msg_level,
  input wire logic msg_accept
);

  // ----------------------------------------
  // Index decode helpers
  // ----------------------------------------
  function automatic logic is_entry(input logic [7:0] idx);
    return idx >= ioare_pkg::IDX_ENTRY_BASE &&
           idx < ioare_pkg::IDX_ENTRY_BASE + 8'(2 * N);
  endfunction

  function automatic logic [6:0] entry_no(input logic [7:0] idx);
    logic [7:0] off;
    off = idx - ioare_pkg::IDX_ENTRY_BASE;
    return off[7:1];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] index_q;
  logic [7:0] vec_q [N];
  logic [2:0] deliv_q [N];
  logic [7:0] dest_q [N];
  logic [N-1:0] logical_q, pol_q, level_q, mask_q, remote_q, pend_q, prev_q;
  ioare_pkg::ioare_state_e st_q;
  logic [4:0] sel_q;

  // Register strobes
  wire wr_index = reg_wr && reg_addr == ioare_pkg::OFS_INDEX;
  wire wr_data = reg_wr && reg_addr == ioare_pkg::OFS_DATA;
  wire wr_pin = reg_wr && reg_addr == ioare_pkg::OFS_PIN;
  wire wr_eoi = reg_wr && reg_addr == ioare_pkg::OFS_EOI;
  wire idx_hit = is_entry(index_q);
  wire [6:0] idx_ent = entry_no(index_q);
  wire take = st_q == ioare_pkg::ST_SEND && msg_valid && msg_accept;

  // ----------------------------------------
  // Per-input event detection
  // ----------------------------------------
  wire [N-1:0] act_w, inject_w, acc_w, eoi_w, wlo_w, whi_w, elig_w, edge_w;
  for (genvar g = 0; g < N; g++)
  begin : g_in
    wire sel_me = idx_hit && idx_ent == 7'(g);
    assign wlo_w[g] = wr_data && sel_me && !index_q[0];
    assign whi_w[g] = wr_data && sel_me && index_q[0];
    assign act_w[g] = irq_in[g] ^ pol_q[g];
    // Edge mode fires on a new assertion, level mode while active
    wire edge_ev = !level_q[g] && act_w[g] && !prev_q[g];
    // A level already covered by the message taken now is not re-pended,
    // otherwise a stale pending would fire after the pin has gone idle
    wire lvl_ev = level_q[g] && act_w[g] && !remote_q[g] &&
                  !acc_w[g];
    wire pin_ev = wr_pin && reg_wdata[4:0] == 5'(g);
    assign inject_w[g] = (edge_ev || lvl_ev || pin_ev) && !mask_q[g];
    assign edge_w[g] = edge_ev && !mask_q[g];
    assign acc_w[g] = take && sel_q == 5'(g);
    assign eoi_w[g] = wr_eoi && reg_wdata[7:0] == vec_q[g];
    // Reserved delivery codes are never sent
    assign elig_w[g] = pend_q[g] && !mask_q[g] &&
                       !(level_q[g] && remote_q[g]) &&
                       deliv_q[g] != ioare_pkg::DELIV_RSVD_A &&
                       deliv_q[g] != ioare_pkg::DELIV_RSVD_B;
  end

  // ----------------------------------------
  // Entry registers
  // ----------------------------------------
  // Set wins over clear on both status bits, so no event is lost
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < N; i++)
      begin
        vec_q[i] <= ioare_pkg::VEC_RST;
        deliv_q[i] <= ioare_pkg::DELIV_RST;
        dest_q[i] <= ioare_pkg::DEST_RST;
      end
      logical_q <= '0;
      pol_q <= '0;
      level_q <= '0;
      mask_q <= '0;
      remote_q <= '0;
      pend_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      prev_q <= act_w;
      for (int i = 0; i < N; i++)
      begin
        if (wlo_w[i])
        begin
          vec_q[i] <= reg_wdata[ioare_pkg::VEC_LSB +: 8];
          deliv_q[i] <= reg_wdata[ioare_pkg::DELIV_LSB +: 3];
          logical_q[i] <= reg_wdata[ioare_pkg::B_LOGICAL];
          pol_q[i] <= reg_wdata[ioare_pkg::B_POLARITY];
          level_q[i] <= reg_wdata[ioare_pkg::B_LEVEL];
          mask_q[i] <= reg_wdata[ioare_pkg::B_MASK];
        end
        if (whi_w[i])
          dest_q[i] <= reg_wdata[ioare_pkg::DEST_LSB +: 8];
        if (inject_w[i])
          pend_q[i] <= 1'b1;
        else if (acc_w[i])
          pend_q[i] <= 1'b0;
        if (acc_w[i] && level_q[i])
          remote_q[i] <= 1'b1;
        else if (eoi_w[i])
          remote_q[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Arbitration: lowest input number first
  // ----------------------------------------
  logic [4:0] pick_w;
  wire any_w = |elig_w;
  always_comb
  begin
    pick_w = '0;
    for (int i = N - 1; i >= 0; i--)
      if (elig_w[i])
        pick_w = 5'(i);
  end

  // Destination as sent: physical mode carries only the 4-bit id
  wire [7:0] dest_w = logical_q[pick_w] ? dest_q[pick_w] :
                      {ioare_pkg::PHYS_PAD, dest_q[pick_w][3:0]};

  // ----------------------------------------
  // Message sender
  // ----------------------------------------
  // The message is latched, so entry edits during an offer do not tear it
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= ioare_pkg::ST_IDLE;
      sel_q <= '0;
      msg_valid <= 1'b0;
      msg_vector <= '0;
      msg_dest <= '0;
      msg_logical <= 1'b0;
      msg_delivery <= '0;
      msg_level <= 1'b0;
    end
    else
    begin
      case (st_q)
        ioare_pkg::ST_IDLE:
          if (any_w)
          begin
            st_q <= ioare_pkg::ST_SEND;
            sel_q <= pick_w;
            msg_valid <= 1'b1;
            msg_vector <= vec_q[pick_w];
            msg_dest <= dest_w;
            msg_logical <= logical_q[pick_w];
            msg_delivery <= deliv_q[pick_w];
            msg_level <= level_q[pick_w];
          end
        ioare_pkg::ST_SEND:
          if (msg_accept)
          begin
            st_q <= ioare_pkg::ST_IDLE;
            msg_valid <= 1'b0;
          end
        default:
        begin
          st_q <= ioare_pkg::ST_IDLE;
          msg_valid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  wire [4:0] re_w = idx_ent[4:0];
  wire [31:0] lo_w = {15'h0000, mask_q[re_w], level_q[re_w],
                      remote_q[re_w], pol_q[re_w], pend_q[re_w],
                      logical_q[re_w], deliv_q[re_w], vec_q[re_w]};
  wire [31:0] hi_w = {dest_q[re_w], 24'h00_0000};
  wire [31:0] ent_w = !idx_hit ? ioare_pkg::WORD_ZERO :
                      index_q[0] ? hi_w : lo_w;
  wire [31:0] rd_w = reg_addr == ioare_pkg::OFS_INDEX ?
                     {24'h00_0000, index_q} :
                     reg_addr == ioare_pkg::OFS_DATA ? ent_w :
                     ioare_pkg::WORD_ZERO;

  // Index register and read data; write-only registers read as zero
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      index_q <= '0;
      reg_rdata <= '0;
    end
    else
    begin
      if (wr_index)
        index_q <= reg_wdata[7:0];
      if (reg_rd)
        reg_rdata <= rd_w;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Entries whose remote flag an end-of-interrupt must clear this cycle
  wire [N-1:0] clr_w = eoi_w & ~acc_w;

  sequence s_offer;
    msg_valid && !msg_accept;
  endsequence
  sequence s_take;
    msg_valid && msg_accept;
  endsequence

  property p_phys;
    $rose(msg_valid) && !msg_logical |->
      msg_dest == {ioare_pkg::PHYS_PAD, dest_q[sel_q][3:0]};
  endproperty
  a_phys: assert property (p_phys) else $error("physical dest wrong");
  property p_logic;
    $rose(msg_valid) && msg_logical |-> msg_dest == dest_q[sel_q];
  endproperty
  a_logic: assert property (p_logic) else $error("logical dest wrong");
  property p_mode;
    $rose(msg_valid) |-> msg_logical == logical_q[sel_q];
  endproperty
  a_mode: assert property (p_mode) else $error("dest mode wrong");
  property p_mask;
    any_w |-> !mask_q[pick_w];
  endproperty
  a_mask: assert property (p_mask) else $error("masked input picked");
  property p_edge;
    |edge_w |=> (pend_q & $past(edge_w)) == $past(edge_w);
  endproperty
  a_edge: assert property (p_edge) else $error("edge not caught");
  property p_remote;
    s_take ##0 msg_level |=> remote_q[$past(sel_q)];
  endproperty
  a_remote: assert property (p_remote) else $error("remote not set");
  property p_eoi;
    |clr_w |=> (remote_q & $past(clr_w)) == '0;
  endproperty
  a_eoi: assert property (p_eoi) else $error("eoi did not clear");
  property p_hold;
    s_offer |=> msg_valid && pend_q[sel_q] && $stable(msg_vector);
  endproperty
  a_hold: assert property (p_hold) else $error("offer dropped");
  property p_pend;
    $rose(msg_valid) |-> pend_q[sel_q];
  endproperty
  a_pend: assert property (p_pend) else $error("sent without pending");
  property p_block;
    any_w |-> !(level_q[pick_w] && remote_q[pick_w]);
  endproperty
  a_block: assert property (p_block) else $error("resend blocked lvl");
  property p_rsvd;
    $rose(msg_valid) |-> msg_delivery != ioare_pkg::DELIV_RSVD_A &&
      msg_delivery != ioare_pkg::DELIV_RSVD_B;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode sent");

endmodule

`default_nettype wire

/* File: tb/ioare_lapic.sv */
// Stand-in for the local interrupt controller that takes routed messages.
// Assumes the sender holds msg_valid and its fields until accepted.
`timescale 1ns/1ps
`default_nettype none
module ioare_lapic (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Message handshake
  input wire logic msg_valid,
  input wire logic [3:0] stall,
  output logic msg_accept
);
  logic [3:0] wait_q;
  // A busy target holds acceptance off for stall cycles
  assign msg_accept = msg_valid && (wait_q == stall);
  // Count how long the current offer has waited
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      wait_q <= 4'h0;
    else if (!msg_valid || msg_accept)
      wait_q <= 4'h0;
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the routing table with a reference model.
// Assumes the design and the local controller stand-in are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, sys_rst, reg_wr, reg_rd, msg_accept, msg_valid;
  logic msg_logical, msg_level;
  logic [7:0] reg_addr, msg_vector, msg_dest;
  logic [31:0] reg_wdata, reg_rdata, rnd, d;
  logic [23:0] irq_in;
  logic [2:0] msg_delivery;
  logic [3:0] stall;
  logic [31:0] lo_m [24];
  logic [31:0] hi_m [24];
  logic [31:0] got [$];
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
  int mismatches, checks_done, cycles;

  ioare_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_in(irq_in),
    .msg_valid(msg_valid), .msg_vector(msg_vector), .msg_dest(msg_dest),
    .msg_logical(msg_logical), .msg_delivery(msg_delivery),
    .msg_level(msg_level), .msg_accept(msg_accept));
  ioare_lapic u_lapic (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .msg_valid(msg_valid), .stall(stall), .msg_accept(msg_accept));

  // ----------------------------------------
  // Clock, message monitor and hang guard
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (msg_valid && msg_accept)
      got.push_back({11'h0, msg_vector, msg_dest, msg_logical,
        msg_delivery, msg_level});
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // Model: physical mode keeps only the low four destination bits
  function automatic logic [31:0] exp_msg(int n);
    return {11'h0, lo_m[n][7:0], lo_m[n][11] ? hi_m[n][31:24] :
      {4'h0, hi_m[n][27:24]}, lo_m[n][11], lo_m[n][10:8], lo_m[n][15]};
  endfunction
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes are dropped a full cycle before the next access
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge ref_clk);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    v = reg_rdata;
  endtask
  task automatic set_e(int n, logic [31:0] lo, logic [31:0] hi);
    wr(ioare_pkg::OFS_INDEX, 32'(ioare_pkg::IDX_ENTRY_BASE) + 32'(2 * n));
    wr(ioare_pkg::OFS_DATA, lo);
    wr(ioare_pkg::OFS_INDEX, 32'(ioare_pkg::IDX_ENTRY_BASE) + 32'(2 * n + 1));
    wr(ioare_pkg::OFS_DATA, hi);
    lo_m[n] = lo & 32'h0001_afff;
    hi_m[n] = hi & 32'hff00_0000;
  endtask
  task automatic rd_w(int i, output logic [31:0] v);
    wr(ioare_pkg::OFS_INDEX, 32'(ioare_pkg::IDX_ENTRY_BASE) + 32'(i));
    rd(ioare_pkg::OFS_DATA, v);
  endtask
  task automatic expect_msg(int n);
    repeat (60) if (got.size() == 0) @(posedge ref_clk);
    // Step off the edge so callers never change inputs on it
    #1 chk(got.size() > 0 ? got.pop_front() : 32'hffff_ffff, exp_msg(n));
  endtask
  task automatic quiet();
    repeat (20) @(posedge ref_clk);
    chk(32'(got.size()), 32'h0000_0000);
  endtask
  task automatic pulse(int n);
    @(posedge ref_clk);
    #1 irq_in[n] = 1'b1;
    @(posedge ref_clk);
    #1 irq_in[n] = 1'b0;
  endtask
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 40'h0};
    {irq_in, stall, rnd} = {28'h0, 32'h0000_2b60};
    repeat (6) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    rd_w(0, d);
    chk(d, 32'h0000_0000);
    rd_w(8'h40, d);
    chk(d, 32'h0000_0000);
    rd(8'h30, d);
    chk(d, 32'h0000_0000);
    set_e(3, 32'hffff_dfff, 32'hffff_ffff);
    rd_w(6, d);
    chk(d, lo_m[3]);
    rd_w(7, d);
    chk(d, hi_m[3]);
    // Every usable delivery mode, both destination modes, random fields
    for (int i = 0; i < 6; i++)
    begin
      stall = 4'(xs());
      set_e(3, {20'h0, 1'(i), modes[i], 8'h10 + 8'(xs() % 239)}, xs());
      pulse(3);
      expect_msg(3);
    end
    stall = 4'hf;
    set_e(6, 32'h0000_0055, 32'h0900_0000);
    pulse(6);
    rd_w(12, d);
    chk(d, lo_m[6] | 32'h0000_1000);
    expect_msg(6);
    rd_w(12, d);
    chk(d, lo_m[6]);
    stall = 4'h0;
    set_e(9, 32'h0001_0020, 32'h0000_0000);
    pulse(9);
    quiet();
    // Reserved modes stay pending; masked afterwards so they cannot leak
    set_e(20, 32'h0000_0330, 32'h0000_0000);
    pulse(20);
    set_e(20, 32'h0000_0630, 32'h0000_0000);
    pulse(20);
    quiet();
    set_e(20, 32'h0001_0030, 32'h0000_0000);
    // Park the pin inactive while masked, so no false level event is taken
    set_e(5, 32'h0001_a077, 32'h0500_0000);
    irq_in[5] = 1'b1;
    set_e(5, 32'h0000_a077, 32'h0500_0000);
    #100 irq_in[5] = 1'b0;
    expect_msg(5);
    rd_w(10, d);
    chk(d & 32'h0000_4000, 32'h0000_4000);
    quiet();
    wr(ioare_pkg::OFS_EOI, 32'h0000_0077);
    expect_msg(5);
    irq_in[5] = 1'b1;
    wr(ioare_pkg::OFS_EOI, 32'h0000_0077);
    rd_w(10, d);
    chk(d & 32'h0000_4000, 32'h0000_0000);
    set_e(4, 32'h0000_0042, 32'h0300_0000);
    wr(ioare_pkg::OFS_PIN, 32'h0000_0004);
    expect_msg(4);
    wr(ioare_pkg::OFS_PIN, 32'h0000_0018);
    quiet();
    finish_test();
  end
endmodule
`default_nettype wire
